// >>> hdl/rui_pkg.sv
/*
  Constants for the clock update and alarm interrupt block: register
  indices, field positions, write masks, reset values and pulse timing.
  Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package rui_pkg;

  localparam int ADDR_W = 6;
  localparam int CNT_W = 21;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_ALM_MIN = 4'h8;
  localparam logic [3:0] IDX_ALM_HOUR = 4'h9;
  localparam logic [3:0] IDX_ALM_WDAY = 4'hA;
  localparam logic [3:0] IDX_EXT = 4'hD;
  localparam logic [3:0] IDX_FLAGS = 4'hE;
  localparam logic [3:0] IDX_CTRL = 4'hF;

  // Field positions
  localparam int EXT_WEEK_DAY_BIT = 6;
  localparam int EXT_UPD_SEL_BIT = 5;
  localparam int FLG_UPDATE_BIT = 5;
  localparam int FLG_ALARM_BIT = 3;
  localparam int CTL_UPD_EN_BIT = 5;
  localparam int CTL_ALM_EN_BIT = 3;
  localparam int CTL_STOP_BIT = 1;
  localparam int CTL_RESET_BIT = 0;
  localparam int ALM_SKIP_BIT = 7;

  // Writable bits of each register
  localparam logic [7:0] EXT_MASK = 8'hF3;
  localparam logic [7:0] FLG_MASK = 8'h28;
  localparam logic [7:0] CTL_MASK = 8'h3B;
  localparam logic [7:0] ALM_MASK = 8'hFF;

  // Values after reset
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] FLG_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] ALM_RESET = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Update pulse: longest time, rounded down to cycles
  localparam int UPD_PULSE_NS = 7_800_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int UPD_PULSE_CYC = UPD_PULSE_NS / CLK_PERIOD_NS;

endpackage

// >>> hdl/rui_update_alarm_irq.sv
/*
  Update and alarm interrupt logic of a real-time clock with its
  extension, flag, control and alarm registers on AXI4-Lite.
  Assumes tick pulses and current time come from timekeeping logic on
  sys_clk; the interrupt pin is open drain, pulled up outside.
*/
// Functional notes
// - Update select picks second or minute events
// - Update event sets update flag, held
// - Writing one to update flag does nothing
// - Clearing update flag keeps update pulse
// - Enabled update event drives pin, auto-release
// - Update enable zero masks and releases pulse
// - Stop or reset bit blocks update events
// - Update detection runs regardless of enable
// - Shared pin, other sources may drive
// - Unused register bits ignore writes, read zero
// - Alarm matches hour, minute, day or weekday
// - Alarm fires only when time advances
// - Alarm event sets alarm flag, held
// - Enabled alarm holds pin until cleared
// - Alarm enable zero releases pin at once
// - Clearing alarm flag releases pin at once
// - Disabled alarm leaves pin, flag still set
// - Field positions of flags and enables
// - Week/day select chooses weekday or date
// - Skip bit drops field from alarm match
`timescale 1ns/1ps
`default_nettype none

module rui_update_alarm_irq #(
  parameter int unsigned UPD_PULSE_CYCLES = rui_pkg::UPD_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cen,
  input wire logic secondTick,
  input wire logic minuteTick,
  input wire logic [6:0] curMinute,
  input wire logic [5:0] curHour,
  input wire logic [6:0] curWeek,
  input wire logic [5:0] curDay,
  input wire logic timerIrq,
  input wire logic [rui_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rui_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic intOut,
  output logic intOe,
  output logic clockStop,
  output logic clockReset
);

  typedef struct packed {
    logic awReady;
    logic awHeld;
    logic [3:0] awIdx;
    logic wReady;
    logic wHeld;
    logic [7:0] wData;
    logic wLane;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
    logic [7:0] ext;
    logic [7:0] flags;
    logic [7:0] ctrl;
    logic [7:0] almMin;
    logic [7:0] almHour;
    logic [7:0] almWday;
    logic updActive;
    logic [rui_pkg::CNT_W-1:0] updCnt;
    logic intOe;
  } rui_state_type;

  rui_state_type st;
  rui_state_type next_st;
  logic running;
  logic updEvent;
  logic almEvent;
  logic wrDo;
  logic wrEn;
  logic wrFlags;
  logic wrCtrl;

  localparam logic [rui_pkg::CNT_W-1:0] PULSE_LOAD = (rui_pkg::CNT_W)'(UPD_PULSE_CYCLES);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic regMapped(input logic [3:0] idx);
    regMapped = (idx == rui_pkg::IDX_ALM_MIN) || (idx == rui_pkg::IDX_ALM_HOUR) ||
                (idx == rui_pkg::IDX_ALM_WDAY) || (idx == rui_pkg::IDX_EXT) ||
                (idx == rui_pkg::IDX_FLAGS) || (idx == rui_pkg::IDX_CTRL);
  endfunction

  function automatic logic alarmHit(input logic [7:0] aMin, input logic [7:0] aHour,
                                    input logic [7:0] aWday, input logic weekDay,
                                    input logic [6:0] tMin, input logic [5:0] tHour,
                                    input logic [6:0] tWeek, input logic [5:0] tDay);
    logic minOk;
    logic hourOk;
    logic dayOk;
    minOk = aMin[rui_pkg::ALM_SKIP_BIT] || (aMin[6:0] == tMin);
    hourOk = aHour[rui_pkg::ALM_SKIP_BIT] || (aHour[5:0] == tHour);
    if (aWday[rui_pkg::ALM_SKIP_BIT]) begin
      dayOk = 1'b1;
    end else if (weekDay) begin
      dayOk = (aWday[5:0] == tDay);
    end else begin
      dayOk = |(aWday[6:0] & tWeek);
    end
    alarmHit = minOk && hourOk && dayOk;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    running = !(st.ctrl[rui_pkg::CTL_STOP_BIT] || st.ctrl[rui_pkg::CTL_RESET_BIT]);
    updEvent = running && (st.ext[rui_pkg::EXT_UPD_SEL_BIT] ? minuteTick : secondTick);
    almEvent = running && minuteTick &&
               alarmHit(st.almMin, st.almHour, st.almWday, st.ext[rui_pkg::EXT_WEEK_DAY_BIT],
                        curMinute, curHour, curWeek, curDay);

    // Write channels, taken in either order
    if (s_axi_awvalid && st.awReady) begin
      next_st.awHeld = 1'b1;
      next_st.awIdx = s_axi_awaddr[5:2];
    end
    if (s_axi_wvalid && st.wReady) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata[7:0];
      next_st.wLane = s_axi_wstrb[0];
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end
    wrDo = st.awHeld && st.wHeld && !st.bValid;
    wrEn = wrDo && st.wLane && regMapped(st.awIdx);
    wrFlags = wrEn && (st.awIdx == rui_pkg::IDX_FLAGS);
    wrCtrl = wrEn && (st.awIdx == rui_pkg::IDX_CTRL);
    if (wrDo) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = regMapped(st.awIdx) ? rui_pkg::RESP_OKAY : rui_pkg::RESP_SLVERR;
    end
    next_st.awReady = !next_st.awHeld;
    next_st.wReady = !next_st.wHeld;

    if (wrEn && st.awIdx == rui_pkg::IDX_EXT) begin
      next_st.ext = st.wData & rui_pkg::EXT_MASK;
    end
    if (wrCtrl) begin
      next_st.ctrl = st.wData & rui_pkg::CTL_MASK;
    end
    if (wrEn && st.awIdx == rui_pkg::IDX_ALM_MIN) begin
      next_st.almMin = st.wData & rui_pkg::ALM_MASK;
    end
    if (wrEn && st.awIdx == rui_pkg::IDX_ALM_HOUR) begin
      next_st.almHour = st.wData & rui_pkg::ALM_MASK;
    end
    if (wrEn && st.awIdx == rui_pkg::IDX_ALM_WDAY) begin
      next_st.almWday = st.wData & rui_pkg::ALM_MASK;
    end
    // Flags only clear on write of zero
    if (wrFlags) begin
      next_st.flags = st.flags & st.wData & rui_pkg::FLG_MASK;
    end
    // Update flag set, wins over clear
    if (updEvent) begin
      next_st.flags[rui_pkg::FLG_UPDATE_BIT] = 1'b1;
    end
    // Alarm flag set, wins over clear
    if (almEvent) begin
      next_st.flags[rui_pkg::FLG_ALARM_BIT] = 1'b1;
    end

    if (st.updActive) begin
      if (st.updCnt <= 1) begin
        next_st.updActive = 1'b0;
      end else begin
        next_st.updCnt = st.updCnt - 1'b1;
      end
    end
    if (updEvent && st.ctrl[rui_pkg::CTL_UPD_EN_BIT]) begin
      next_st.updActive = 1'b1;
      next_st.updCnt = PULSE_LOAD;
    end
    // Enable low masks and releases pulse
    if (!next_st.ctrl[rui_pkg::CTL_UPD_EN_BIT]) begin
      next_st.updActive = 1'b0;
    end

    // Alarm holds while flag and enable
    next_st.intOe = next_st.updActive || timerIrq ||
                    (next_st.flags[rui_pkg::FLG_ALARM_BIT] &&
                     next_st.ctrl[rui_pkg::CTL_ALM_EN_BIT]);

    // Read channel
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
      next_st.arReady = 1'b1;
    end
    if (s_axi_arvalid && st.arReady) begin
      next_st.arReady = 1'b0;
      next_st.rValid = 1'b1;
      next_st.rResp = regMapped(s_axi_araddr[5:2]) ? rui_pkg::RESP_OKAY : rui_pkg::RESP_SLVERR;
      case (s_axi_araddr[5:2])
        rui_pkg::IDX_ALM_MIN: begin
          next_st.rData = st.almMin;
        end
        rui_pkg::IDX_ALM_HOUR: begin
          next_st.rData = st.almHour;
        end
        rui_pkg::IDX_ALM_WDAY: begin
          next_st.rData = st.almWday;
        end
        rui_pkg::IDX_EXT: begin
          next_st.rData = st.ext;
        end
        rui_pkg::IDX_FLAGS: begin
          next_st.rData = st.flags;
        end
        rui_pkg::IDX_CTRL: begin
          next_st.rData = st.ctrl;
        end
        default: begin
          next_st.rData = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st <= '0;
      st.awReady <= 1'b1;
      st.wReady <= 1'b1;
      st.arReady <= 1'b1;
      st.ext <= rui_pkg::EXT_RESET;
      st.flags <= rui_pkg::FLG_RESET;
      st.ctrl <= rui_pkg::CTL_RESET;
      st.almMin <= rui_pkg::ALM_RESET;
      st.almHour <= rui_pkg::ALM_RESET;
      st.almWday <= rui_pkg::ALM_RESET;
    end else if (cen) begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awReady;
  assign s_axi_wready = st.wReady;
  assign s_axi_bvalid = st.bValid;
  assign s_axi_bresp = st.bResp;
  assign s_axi_arready = st.arReady;
  assign s_axi_rvalid = st.rValid;
  assign s_axi_rresp = st.rResp;
  assign s_axi_rdata = {24'h00_0000, st.rData};
  assign intOut = 1'b0;
  assign intOe = st.intOe;
  assign clockStop = st.ctrl[rui_pkg::CTL_STOP_BIT];
  assign clockReset = st.ctrl[rui_pkg::CTL_RESET_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn || !cen);

  AST_UPD_FLAG_SET: assert property (updEvent |=> st.flags[rui_pkg::FLG_UPDATE_BIT])
    else $error("Update flag not set after update event");

  AST_UPD_FLAG_W1: assert property (wrFlags && st.wData[rui_pkg::FLG_UPDATE_BIT] &&
      !st.flags[rui_pkg::FLG_UPDATE_BIT] && !updEvent |=> !st.flags[rui_pkg::FLG_UPDATE_BIT])
    else $error("Writing one set the update flag");

  AST_UPD_DRIVE: assert property (updEvent && st.ctrl[rui_pkg::CTL_UPD_EN_BIT] && !wrCtrl
      |=> st.intOe && st.updCnt == PULSE_LOAD)
    else $error("Enabled update event did not drive pin");

  AST_UPD_BOUND: assert property (st.updActive |-> st.updCnt <= PULSE_LOAD && st.updCnt != 0)
    else $error("Update pulse counter out of range");

  AST_UPD_MASKED: assert property (updEvent && !st.ctrl[rui_pkg::CTL_UPD_EN_BIT]
      |=> !st.updActive)
    else $error("Masked update event started a pulse");

  AST_UPD_KEEP: assert property (st.updActive && st.updCnt > 1 && wrFlags && !wrCtrl
      |=> st.intOe)
    else $error("Clearing update flag released the pin");

  AST_STOP_BLOCK: assert property (!running && !wrFlags
      |=> $stable(st.flags[rui_pkg::FLG_UPDATE_BIT]))
    else $error("Update event while stopped");

  AST_ALM_FLAG_SET: assert property (almEvent |=> st.flags[rui_pkg::FLG_ALARM_BIT])
    else $error("Alarm flag not set after alarm event");

  AST_ALM_HOLD: assert property (st.flags[rui_pkg::FLG_ALARM_BIT] &&
      st.ctrl[rui_pkg::CTL_ALM_EN_BIT] && !wrFlags && !wrCtrl
      |=> st.intOe && st.flags[rui_pkg::FLG_ALARM_BIT] && st.ctrl[rui_pkg::CTL_ALM_EN_BIT])
    else $error("Alarm did not hold the pin");

  AST_ALM_RELEASE: assert property (wrFlags && !st.wData[rui_pkg::FLG_ALARM_BIT] &&
      !almEvent && !timerIrq && !st.updActive && !updEvent |=> !st.intOe)
    else $error("Clearing alarm flag did not release pin");

  AST_ALM_EN_OFF: assert property (wrCtrl && !st.wData[rui_pkg::CTL_ALM_EN_BIT] &&
      !timerIrq && !updEvent && !st.updActive |=> !st.intOe)
    else $error("Alarm enable off did not release pin");

  AST_RESERVED_FLG: assert property ($rose(s_axi_rvalid) &&
      $past(s_axi_araddr[5:2]) == rui_pkg::IDX_FLAGS
      |-> (st.rData & ~rui_pkg::FLG_MASK) == 8'h00)
    else $error("Reserved flag bits read nonzero");

  AST_RESERVED_CTL: assert property ($rose(s_axi_rvalid) &&
      $past(s_axi_araddr[5:2]) == rui_pkg::IDX_CTRL
      |-> (st.rData & ~rui_pkg::CTL_MASK) == 8'h00)
    else $error("Reserved control bits read nonzero");

  AST_UPD_SEL: assert property (running && minuteTick && !secondTick &&
      !st.ext[rui_pkg::EXT_UPD_SEL_BIT] && !st.flags[rui_pkg::FLG_UPDATE_BIT]
      |=> !st.flags[rui_pkg::FLG_UPDATE_BIT])
    else $error("Minute tick raised update while seconds selected");

  AST_UPD_END: assert property (st.updActive && st.updCnt == 1 && !updEvent
      |=> !st.updActive)
    else $error("Update pulse did not end");

  AST_ALM_MASKED: assert property (almEvent && !wrCtrl &&
      !st.ctrl[rui_pkg::CTL_ALM_EN_BIT] && !timerIrq && !st.updActive && !updEvent
      |=> !st.intOe && st.flags[rui_pkg::FLG_ALARM_BIT])
    else $error("Disabled alarm drove the pin");

  AST_ALM_QUIET: assert property (!minuteTick && !st.flags[rui_pkg::FLG_ALARM_BIT]
      |=> !st.flags[rui_pkg::FLG_ALARM_BIT])
    else $error("Alarm flag rose without time advance");

  AST_TIMER_PIN: assert property (timerIrq && !st.ctrl[rui_pkg::CTL_UPD_EN_BIT]
      |=> st.intOe)
    else $error("Timer request did not drive the pin");

endmodule

`default_nettype wire

// >>> testbench/rui_time_model.sv
/*
  Timekeeping partner: gives second and minute ticks and the current time.
  Assumes the bench raises a request for one sys_clk cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rui_time_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic secReq,
  input wire logic minReq,
  output logic secondTick,
  output logic minuteTick,
  output logic [6:0] curMinute,
  output logic [5:0] curHour,
  output logic [6:0] curWeek,
  output logic [5:0] curDay
);
  assign curHour = 6'h00;
  assign curWeek = 7'h02;
  assign curDay = 6'h01;
  // New minute shows in the tick cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      secondTick <= 1'b0;
      minuteTick <= 1'b0;
      curMinute <= 7'h00;
    end else begin
      secondTick <= secReq;
      minuteTick <= minReq;
      if (minReq) begin
        curMinute <= curMinute + 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/rui_update_alarm_irq_tb.sv
/*
  Testbench: AXI4-Lite register access, tick and alarm scenarios.
  Assumes the time model partner and a short update pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module rui_update_alarm_irq_tb;
  localparam int PULSE = 16;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic secReq = 1'b0;
  logic minReq = 1'b0;
  logic timerIrq = 1'b0;
  logic secondTick, minuteTick, intOut, intOe, clockStop, clockReset;
  logic [6:0] curMinute, curWeek;
  logic [5:0] curHour, curDay;
  logic [5:0] awAddr = 6'h00;
  logic [5:0] arAddr = 6'h00;
  logic [31:0] wData = 32'h0000_0000;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp, lastResp;
  logic [31:0] rData;
  int oeRun = 0;
  int lastRun = 0;
  int cycles = 0;
  int fails = 0;
  int checksDone = 0;

  rui_time_model u_time (.sys_clk(sys_clk), .resetn(resetn), .secReq(secReq),
    .minReq(minReq), .secondTick(secondTick), .minuteTick(minuteTick),
    .curMinute(curMinute), .curHour(curHour), .curWeek(curWeek), .curDay(curDay));

  rui_update_alarm_irq #(.UPD_PULSE_CYCLES(PULSE)) u_dut (.sys_clk(sys_clk),
    .resetn(resetn), .cen(1'b1), .secondTick(secondTick), .minuteTick(minuteTick),
    .curMinute(curMinute), .curHour(curHour), .curWeek(curWeek), .curDay(curDay),
    .timerIrq(timerIrq), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .intOut(intOut), .intOe(intOe), .clockStop(clockStop), .clockReset(clockReset));

  always #2.5 sys_clk = ~sys_clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Pin pulse length monitor and timeout
  always @(posedge sys_clk) begin
    cycles++;
    if (intOe === 1'b1) begin
      oeRun++;
    end else if (oeRun != 0) begin
      lastRun = oeRun;
      oeRun = 0;
    end
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic cmpReg(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awAddr <= {idx, 2'b00};
    wData <= {24'h00_0000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (1'b1) begin
      @(posedge sys_clk);
      if (!aw && !w && bValid === 1'b1) break;
      if (aw && awReady === 1'b1) begin
        aw = 1'b0;
        awValid <= 1'b0;
      end
      if (w && wReady === 1'b1) begin
        w = 1'b0;
        wValid <= 1'b0;
      end
    end
    lastResp = bResp;
    bReady <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic chk(input logic [3:0] idx, input logic [7:0] exp);
    arAddr <= {idx, 2'b00};
    arValid <= 1'b1;
    rReady <= 1'b1;
    @(posedge sys_clk);
    while (arReady !== 1'b1) begin
      @(posedge sys_clk);
    end
    arValid <= 1'b0;
    while (rValid !== 1'b1) begin
      @(posedge sys_clk);
    end
    lastResp = rResp;
    rReady <= 1'b0;
    cmpReg(rData[7:0], exp);
    @(posedge sys_clk);
  endtask

  task automatic tick(input logic isMin);
    secReq <= !isMin;
    minReq <= isMin;
    @(posedge sys_clk);
    secReq <= 1'b0;
    minReq <= 1'b0;
    waitCyc(3);
  endtask

  initial begin
    waitCyc(5);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk(4'hD, 8'h00);
    chk(4'hE, 8'h00);
    chk(4'hF, 8'h00);
    wr(4'hD, 8'hFF);
    chk(4'hD, 8'hF3);
    wr(4'hD, 8'h00);
    wr(4'hF, 8'hFF);
    chk(4'hF, 8'h3B);
    cmpBit(clockStop & clockReset, 1'b1);
    tick(1'b0);
    cmpBit(intOe, 1'b0);
    chk(4'hE, 8'h00);
    wr(4'hF, 8'h00);
    cmpBit(clockStop | clockReset, 1'b0);
    wr(4'hE, 8'hFF);
    cmpReg({6'h00, lastResp}, {6'h00, rui_pkg::RESP_OKAY});
    chk(4'hE, 8'h00);
    cmpReg({6'h00, lastResp}, {6'h00, rui_pkg::RESP_OKAY});
    chk(4'h3, 8'h00);
    cmpReg({6'h00, lastResp}, {6'h00, rui_pkg::RESP_SLVERR});
    wr(4'h3, 8'hFF);
    cmpReg({6'h00, lastResp}, {6'h00, rui_pkg::RESP_SLVERR});
    tick(1'b0);
    cmpBit(intOe, 1'b0);
    cmpBit(intOut, 1'b0);
    chk(4'hE, 8'h20);
    wr(4'hE, 8'h20);
    chk(4'hE, 8'h20);
    wr(4'hE, 8'h00);
    chk(4'hE, 8'h00);
    wr(4'hD, 8'h20);
    tick(1'b0);
    chk(4'hE, 8'h00);
    tick(1'b1);
    chk(4'hE, 8'h20);
    wr(4'hD, 8'h00);
    wr(4'hF, 8'h20);
    tick(1'b0);
    wr(4'hE, 8'h00);
    cmpBit(intOe, 1'b1);
    waitCyc(PULSE);
    cmpReg(lastRun[7:0], PULSE[7:0]);
    tick(1'b0);
    wr(4'hF, 8'h00);
    waitCyc(2);
    cmpBit(intOe, 1'b0);
    timerIrq <= 1'b1;
    waitCyc(3);
    cmpBit(intOe, 1'b1);
    timerIrq <= 1'b0;
    waitCyc(3);
    cmpBit(intOe, 1'b0);
    wr(4'hE, 8'h00);
    wr(4'h8, 8'h01);
    wr(4'h9, 8'h00);
    wr(4'hA, 8'h80);
    waitCyc(4);
    chk(4'hE, 8'h00);
    wr(4'h8, 8'h02);
    wr(4'hF, 8'h08);
    tick(1'b1);
    waitCyc(30);
    cmpBit(intOe, 1'b1);
    chk(4'hE, 8'h08);
    wr(4'hE, 8'h00);
    waitCyc(2);
    cmpBit(intOe, 1'b0);
    wr(4'h8, 8'h03);
    tick(1'b1);
    cmpBit(intOe, 1'b1);
    wr(4'hF, 8'h00);
    waitCyc(2);
    cmpBit(intOe, 1'b0);
    chk(4'hE, 8'h08);
    wr(4'hE, 8'h00);
    wr(4'h8, 8'h80);
    wr(4'h9, 8'h80);
    tick(1'b1);
    cmpBit(intOe, 1'b0);
    chk(4'hE, 8'h08);
    wr(4'hE, 8'h00);
    wr(4'hA, 8'h01);
    tick(1'b1);
    chk(4'hE, 8'h00);
    wr(4'hD, 8'h40);
    tick(1'b1);
    chk(4'hE, 8'h08);
    print_verdict();
  end
endmodule
`default_nettype wire
